// file: design/bria_pkg.sv
package bria_pkg;

  // Register byte offsets on the Wishbone slave
  localparam logic [7:0] BRIA_BUS_CTRL_OFF = 8'h00;
  localparam logic [7:0] BRIA_WAIT_CTRL_OFF = 8'h04;
  localparam logic [7:0] BRIA_STATUS_OFF = 8'h08;

  // bus_ctrl_reg fields
  localparam int BRIA_BCR_BROM_EN_POS = 7;
  localparam int BRIA_BCR_BURST_LEN_POS = 6;
  localparam int BRIA_BCR_WORD_CNT_POS = 5;
  localparam int BRIA_BCR_IDLE_EN_POS = 4;
  localparam logic [7:0] BRIA_BCR_RESET = 8'h00;
  localparam logic [7:0] BRIA_BCR_MASK = 8'hf0;

  // wait_state_ctrl_reg fields
  localparam int BRIA_WAIT_STATE_CTRL_REG_FULL_ST_POS = 5;
  localparam int BRIA_WAIT_STATE_CTRL_REG_PIN_WAIT_POS = 4;
  localparam int BRIA_WAIT_STATE_CTRL_REG_WAIT_CNT_LSB = 0;
  localparam int BRIA_WAIT_STATE_CTRL_REG_WAIT_CNT_W = 2;
  localparam logic [7:0] BRIA_WAIT_STATE_CTRL_REG_RESET = 8'h23;
  localparam logic [7:0] BRIA_WAIT_STATE_CTRL_REG_MASK = 8'h33;

  // Burst sizes in words
  localparam logic [3:0] BRIA_BURST_SHORT = 4'h4;
  localparam logic [3:0] BRIA_BURST_LONG = 4'h8;

  // Address step of one 16-bit beat
  localparam logic [23:0] BRIA_BEAT_STEP = 24'h000002;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_ICYC,
    ST_T1,
    ST_T2,
    ST_TW,
    ST_T3,
    ST_B1,
    ST_B2,
    ST_FIN
  } bria_state_t;

endpackage : bria_pkg

// file: design/bria_seq.sv
// Behaviour
// R01: full_access_state_sel picks 3-state full access with waits, else 2-state without.
// R02: Each burst beat lasts one or two states per burst_cycle_len_sel.
// R03: Burst beats never take programmed or pin wait states.
// R04: Burst holds at most four words, or eight when burst_word_count_sel is set.
// R05: Full access of a burst read takes programmed and pin waits like basic cycles.
// R06: With idle_insert_enable, a write right after a read starts with one idle state.
// R07: Idle state drives next address and io_select_n, floats data, strobes high.
// R08: Arbiter grants the highest-priority pending requester among CPU and transfer controller.
// R09: Granted master owns the bus until its acknowledge is withdrawn.
// R10: CPU is lowest priority; pending controller request always wins the bus eventually.
// R11: Handover from CPU only between bus cycles, never inside a locked split access; code hands over at once when cpu_sleep_i and dtc_breq_i are high.
// R12: With the CPU asleep, a controller request is granted at once.
// R13: Transfer controller requests on activation and holds the bus until done.
// R14: burst_rom_enable makes the external space burst ROM space.
// R15: Bursts only for CPU instruction fetches; other accesses are single full accesses.
// R16: Programmed wait count between second and third states follows program_wait_count.
// R17: In pin wait mode, waits continue while the wait input is low.
// R18: With no controller request pending, the CPU keeps the bus.
//
// Decided for this implementation: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps
module bria_seq
  import bria_pkg::*;
#(
  parameter int WB_AW = 8,
  parameter logic [15:0] IO_PAGE = 16'hffff
) (
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [WB_AW-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Arbitration
  input wire logic cpu_breq_i,
  input wire logic cpu_lock_i,
  input wire logic cpu_sleep_i,
  input wire logic dtc_breq_i,
  output logic cpu_back_o,
  output logic dtc_back_o,
  // Access request from the current bus owner
  input wire logic req_valid_i,
  input wire logic req_we_i,
  input wire logic req_fetch_i,
  input wire logic [23:0] req_addr_i,
  input wire logic [15:0] req_wdata_i,
  input wire logic req_hi_i,
  input wire logic req_lo_i,
  input wire logic [3:0] req_words_i,
  output logic rdata_valid_o,
  output logic [15:0] rdata_o,
  output logic done_o,
  // External bus pins
  output logic [23:0] addr_o,
  output logic io_select_n_o,
  output logic address_strobe_n_o,
  output logic read_strobe_n_o,
  output logic upper_write_strobe_n_o,
  output logic lower_write_strobe_n_o,
  output logic [15:0] data_o,
  output logic data_oe_n_o,
  input wire logic [15:0] data_i,
  input wire logic wait_n_i
);

  // Decoder compares against 8-bit offsets, so wider buses cannot be served
  if (WB_AW < 4 || WB_AW > 8) begin : g_chk
    $error("bria_seq: WB_AW must be between 4 and 8");
  end

  typedef struct packed {
    bria_state_t st;
    logic [7:0] bus_ctrl_reg;
    logic [7:0] wait_state_ctrl_reg;
    logic wb_ack;
    logic [31:0] wb_dat;
    logic [1:0] wait_s;
    logic [15:0] din_s1;
    logic [15:0] din_s2;
    logic grant_dtc;
    logic [1:0] wcnt;
    logic [2:0] words_left;
    logic we;
    logic hi;
    logic lo;
    logic last_rd;
    logic [23:0] addr;
    logic ios_n;
    logic as_n;
    logic rd_n;
    logic hwr_n;
    logic lwr_n;
    logic doe_n;
    logic [15:0] dout;
    logic cap0;
    logic cap1;
    logic last0;
    logic last1;
    logic rvalid;
    logic [15:0] rdata;
    logic done;
  } bria_regs_t;

  bria_regs_t q;
  bria_regs_t d;

  function automatic logic hit(input logic [WB_AW-1:0] a, input logic [7:0] off);
    hit = (a[WB_AW-1:2] == off[WB_AW-1:2]);
  endfunction : hit

  function automatic logic io_sel_n(input logic [23:0] a);
    io_sel_n = (a[23:8] != IO_PAGE);
  endfunction : io_sel_n

  // Beats that follow the full access
  function automatic logic [2:0] extra_beats(input logic burst_ok, input logic long_sel,
                                             input logic [3:0] want);
    logic [3:0] lim;
    logic [3:0] n;
    lim = long_sel ? BRIA_BURST_LONG : BRIA_BURST_SHORT;
    n = (want > lim) ? lim : want;
    if (!burst_ok || n == 4'h0) begin
      extra_beats = 3'h0;
    end else begin
      extra_beats = 3'(n - 4'h1);
    end
  endfunction : extra_beats

  logic full3;
  logic pin_wait;
  logic [1:0] prog_wait;
  logic long_beat;
  logic word_end;
  logic wait_low;
  logic brom;

  always_comb begin
    full3 = q.wait_state_ctrl_reg[BRIA_WAIT_STATE_CTRL_REG_FULL_ST_POS];
    pin_wait = q.wait_state_ctrl_reg[BRIA_WAIT_STATE_CTRL_REG_PIN_WAIT_POS];
    prog_wait = q.wait_state_ctrl_reg[BRIA_WAIT_STATE_CTRL_REG_WAIT_CNT_LSB +: BRIA_WAIT_STATE_CTRL_REG_WAIT_CNT_W];
    long_beat = q.bus_ctrl_reg[BRIA_BCR_BURST_LEN_POS];
    brom = q.bus_ctrl_reg[BRIA_BCR_BROM_EN_POS]; // R14
    wait_low = !q.wait_s[1];
    d = q;

    // Pin synchronisers
    d.wait_s = {q.wait_s[0], wait_n_i};
    d.din_s1 = data_i;
    d.din_s2 = q.din_s1;

    // Read return pipeline lines up with the data synchroniser
    d.cap0 = 1'b0;
    d.last0 = 1'b0;
    d.cap1 = q.cap0;
    d.last1 = q.last0;
    d.rvalid = q.cap1;
    d.rdata = q.cap1 ? q.din_s2 : q.rdata;
    d.done = q.last1;

    // Wishbone slave, one-cycle answer
    d.wb_ack = wb_cyc_i && wb_stb_i && !q.wb_ack;
    if (wb_cyc_i && wb_stb_i && !q.wb_ack) begin
      d.wb_dat = 32'h00000000;
      if (hit(wb_adr_i, BRIA_BUS_CTRL_OFF)) begin
        d.wb_dat = {24'h000000, q.bus_ctrl_reg};
        if (wb_we_i && wb_sel_i[0]) begin
          d.bus_ctrl_reg = wb_dat_i[7:0] & BRIA_BCR_MASK;
        end
      end else if (hit(wb_adr_i, BRIA_WAIT_CTRL_OFF)) begin
        d.wb_dat = {24'h000000, q.wait_state_ctrl_reg};
        if (wb_we_i && wb_sel_i[0]) begin
          d.wait_state_ctrl_reg = wb_dat_i[7:0] & BRIA_WAIT_STATE_CTRL_REG_MASK;
        end
      end else if (hit(wb_adr_i, BRIA_STATUS_OFF)) begin
        d.wb_dat = {26'h0000000, q.grant_dtc, q.st != ST_IDLE, q.last_rd, q.words_left};
      end
    end

    // Arbitration
    if (cpu_sleep_i && dtc_breq_i) begin
      d.grant_dtc = 1'b1; // R12
    end else if (q.st == ST_IDLE) begin
      if (dtc_breq_i && !cpu_lock_i) begin
        d.grant_dtc = 1'b1; // R08 R10 R11
      end else if (!dtc_breq_i) begin
        d.grant_dtc = 1'b0; // R09 R18
      end
    end

    word_end = 1'b0;
    unique case (q.st)
      ST_IDLE: begin
        if (req_valid_i && d.grant_dtc == q.grant_dtc && (q.grant_dtc || cpu_breq_i)) begin
          d.we = req_we_i;
          d.hi = req_hi_i;
          d.lo = req_lo_i;
          d.addr = req_addr_i;
          d.ios_n = io_sel_n(req_addr_i);
          d.dout = req_wdata_i;
          // R15 R04
          d.words_left = extra_beats(brom && req_fetch_i && !req_we_i && !q.grant_dtc,
                                     q.bus_ctrl_reg[BRIA_BCR_WORD_CNT_POS], req_words_i);
          if (req_we_i && q.last_rd && q.bus_ctrl_reg[BRIA_BCR_IDLE_EN_POS]) begin
            d.st = ST_ICYC; // R06
          end else begin
            d.st = ST_T1;
            d.as_n = 1'b0;
            d.rd_n = req_we_i;
            d.doe_n = !req_we_i;
          end
        end
      end
      ST_ICYC: begin
        // R07: strobes already high, data floating, next address out
        d.st = ST_T1;
        d.as_n = 1'b0;
        d.doe_n = 1'b0;
      end
      ST_T1: begin
        d.st = ST_T2;
        d.wcnt = full3 ? prog_wait : 2'h0; // R16
        d.hwr_n = !(q.we && q.hi);
        d.lwr_n = !(q.we && q.lo);
      end
      ST_T2, ST_TW: begin
        if (!full3) begin
          word_end = 1'b1; // R01
        end else if (q.wcnt != 2'h0) begin
          d.st = ST_TW; // R05 R16
          d.wcnt = q.wcnt - 2'h1;
        end else if (pin_wait && wait_low) begin
          d.st = ST_TW; // R05 R17
        end else begin
          d.st = ST_T3;
        end
      end
      ST_T3: begin
        word_end = 1'b1;
      end
      ST_B1: begin
        if (long_beat) begin
          d.st = ST_B2; // R02
        end else begin
          word_end = 1'b1; // R03
        end
      end
      ST_B2: begin
        word_end = 1'b1; // R03
      end
      ST_FIN: begin
        if (q.done) begin
          d.st = ST_IDLE;
        end
      end
    endcase

    if (word_end) begin
      d.cap0 = !q.we;
      if (q.words_left != 3'h0) begin
        // Strobes stay low across beats; only the address and io_select_n move
        d.st = ST_B1;
        d.words_left = q.words_left - 3'h1;
        d.addr = q.addr + BRIA_BEAT_STEP;
        d.ios_n = io_sel_n(q.addr + BRIA_BEAT_STEP);
      end else begin
        d.st = ST_FIN;
        d.last0 = 1'b1;
        d.last_rd = !q.we;
        d.as_n = 1'b1;
        d.rd_n = 1'b1;
        d.hwr_n = 1'b1;
        d.lwr_n = 1'b1;
        d.doe_n = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
      q.st <= ST_IDLE;
      q.bus_ctrl_reg <= BRIA_BCR_RESET;
      q.wait_state_ctrl_reg <= BRIA_WAIT_STATE_CTRL_REG_RESET;
      q.wait_s <= 2'b11;
      q.ios_n <= 1'b1;
      q.as_n <= 1'b1;
      q.rd_n <= 1'b1;
      q.hwr_n <= 1'b1;
      q.lwr_n <= 1'b1;
      q.doe_n <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign wb_dat_o = q.wb_dat;
  assign wb_ack_o = q.wb_ack;
  assign cpu_back_o = !q.grant_dtc;
  assign dtc_back_o = q.grant_dtc;
  assign rdata_valid_o = q.rvalid;
  assign rdata_o = q.rdata;
  assign done_o = q.done;
  assign addr_o = q.addr;
  assign io_select_n_o = q.ios_n;
  assign address_strobe_n_o = q.as_n;
  assign read_strobe_n_o = q.rd_n;
  assign upper_write_strobe_n_o = q.hwr_n;
  assign lower_write_strobe_n_o = q.lwr_n;
  assign data_o = q.dout;
  assign data_oe_n_o = q.doe_n;

endmodule : bria_seq

// file: tb/bria_mem_model.sv
`timescale 1ns/1ps
module bria_mem_model (
  input wire logic clk_i,
  input wire logic [23:0] addr_o,
  input wire logic address_strobe_n_o,
  input wire logic read_strobe_n_o,
  input wire logic upper_write_strobe_n_o,
  input wire logic [15:0] data_o,
  input wire logic [3:0] slow_i,
  output logic [15:0] data_i,
  output logic wait_n_i,
  output logic [39:0] last_wr_o
);
  logic [3:0] cnt_q = 4'h0;
  logic as_q = 1'b1;
  // Released bus shows the inverse, so stale data never matches
  assign data_i = {16{read_strobe_n_o}} ^ addr_o[15:0] ^ 16'h5a5a;
  assign wait_n_i = (cnt_q == 4'h0);
  always @(posedge clk_i) begin
    as_q <= address_strobe_n_o;
    if (as_q && !address_strobe_n_o) cnt_q <= slow_i;
    else if (cnt_q != 4'h0) cnt_q <= cnt_q - 4'h1;
    if (!upper_write_strobe_n_o) last_wr_o <= {addr_o, data_o};
  end
endmodule : bria_mem_model

// file: tb/bria_seq_asserts.sv
`timescale 1ns/1ps
module bria_seq_asserts #(
  parameter logic [15:0] IO_PAGE = 16'hffff
) (
  input wire logic clk_i,
  input wire logic [23:0] addr_o,
  input wire logic io_select_n_o,
  input wire logic lower_write_strobe_n_o,
  input wire logic rst_i,
  input wire logic cpu_lock_i,
  input wire logic cpu_sleep_i,
  input wire logic dtc_breq_i,
  input wire logic cpu_back_o,
  input wire logic dtc_back_o,
  input wire logic read_strobe_n_o,
  input wire logic upper_write_strobe_n_o,
  input wire logic data_oe_n_o,
  input wire logic rdata_valid_o,
  input wire logic done_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_grant_excl: assert property (cpu_back_o != dtc_back_o)
    else $error("grant clash");
  a_sleep_grant: assert property (cpu_sleep_i && dtc_breq_i |-> ##[1:2] dtc_back_o)
    else $error("sleep grant late");
  a_lock_keep: assert property (cpu_lock_i && !cpu_sleep_i && cpu_back_o |=> cpu_back_o)
    else $error("handover in split access");
  a_dtc_keep: assert property (dtc_back_o && dtc_breq_i |=> dtc_back_o)
    else $error("controller lost bus");
  a_cpu_default: assert property ($fell(dtc_breq_i) |-> ##[1:6] cpu_back_o)
    else $error("bus not returned");
  a_rd_float: assert property (!read_strobe_n_o |-> data_oe_n_o)
    else $error("data driven in read");
  a_wr_drive: assert property (!upper_write_strobe_n_o |-> !data_oe_n_o && read_strobe_n_o)
    else $error("write strobe without data");
  a_lwr_drive: assert property (!lower_write_strobe_n_o |-> !data_oe_n_o && read_strobe_n_o)
    else $error("lower write strobe without data");
  a_io_select: assert property (io_select_n_o == (addr_o[23:8] != IO_PAGE))
    else $error("io select does not follow address");
  a_beat_gap: assert property (rdata_valid_o && !done_o |=> ##[0:1] rdata_valid_o)
    else $error("burst beat stretched");
endmodule : bria_seq_asserts

bind bria_seq bria_seq_asserts #(.IO_PAGE(IO_PAGE)) chk_u (.clk_i, .addr_o, .io_select_n_o,
  .lower_write_strobe_n_o, .rst_i, .cpu_lock_i, .cpu_sleep_i, .dtc_breq_i,
  .cpu_back_o, .dtc_back_o, .read_strobe_n_o, .upper_write_strobe_n_o, .data_oe_n_o,
  .rdata_valid_o, .done_o);

// file: tb/burst_rom_idle_arbiter_bench.sv
`timescale 1ns/1ps
module burst_rom_idle_arbiter_bench;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, cpu_breq_i, cpu_lock_i;
  logic cpu_sleep_i, dtc_breq_i, cpu_back_o, dtc_back_o, req_valid_i, req_we_i, req_fetch_i;
  logic rdata_valid_o, done_o, io_select_n_o, address_strobe_n_o, read_strobe_n_o, wait_n_i;
  logic upper_write_strobe_n_o, lower_write_strobe_n_o, data_oe_n_o;
  logic [7:0] wb_adr_i;
  logic [31:0] wb_dat_i, wb_dat_o, v;
  logic [23:0] req_addr_i, addr_o;
  logic [15:0] req_wdata_i, rdata_o, data_o, data_i;
  logic [3:0] req_words_i, slow;
  logic [39:0] last_wr, expq[$];
  int failures = 0, n_tests = 0, seed = 32'h3264, k, c;
  bria_seq dut_u (.*, .wb_sel_i(4'hf), .req_hi_i(1'b1), .req_lo_i(1'b1));
  bria_mem_model mem_u (.*, .slow_i(slow), .last_wr_o(last_wr));
  initial begin
    clk_i = 0;
    forever #20 clk_i = ~clk_i;
  end
  task automatic chk(input logic [39:0] g, input logic [39:0] e);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("Error %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic test_done(input int hung);
    failures += hung;
    $display("checks %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : test_done
  always @(posedge clk_i) begin
    if (rdata_valid_o === 1'b1) chk(rdata_o, expq.pop_front());
    if (wb_ack_o === 1'b1 && !wb_we_i) chk(wb_dat_o, expq.pop_front());
    if (done_o === 1'b1 && req_we_i) chk(last_wr, expq.pop_front());
  end
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, a, d};
    if (!we) expq.push_back({8'h0, d});
    for (k = 0; k < 50 && wb_ack_o !== 1'b1; k++) @(posedge clk_i);
    if (k == 50) test_done(1);
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask : wb
  task automatic acc(input logic we, f, input logic [23:0] a, input logic [3:0] w, input int n);
    for (int i = 0; i < n; i++) expq.push_back((a[15:0] + 16'(2 * i)) ^ 16'h5a5a);
    if (we) expq.push_back({a, ~a[15:0]});
    @(posedge clk_i);
    {req_valid_i, req_we_i, req_fetch_i, req_addr_i, req_words_i} <= {1'b1, we, f, a, w};
    req_wdata_i <= ~a[15:0];
    for (k = 0; k < 200 && done_o !== 1'b1; k++) @(posedge clk_i);
    if (k == 200) test_done(1);
    req_valid_i <= 0;
  endtask : acc
  initial begin
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, req_valid_i, req_we_i, req_fetch_i} = '0;
    {req_addr_i, req_wdata_i, req_words_i, cpu_lock_i, cpu_sleep_i, dtc_breq_i, slow} = '0;
    cpu_breq_i = 1;
    rst_i = 1;
    repeat (20) @(posedge clk_i);
    rst_i <= 0;
    wb(0, 8'h04, 32'h23);
    wb(0, 8'h0c, 32'h00);
    wb(1, 8'h00, 32'hff);
    wb(0, 8'h00, 32'hf0);
    wb(1, 8'h04, 32'h31);
    slow <= 4'h3;
    for (c = 0; c < 3; c++) begin
      v = $random(seed);
      acc(0, 0, {8'h00, v[15:1], 1'b0}, 4'h0, 1);
    end
    $display("registers and waits done");
    for (c = 0; c < 4; c++) begin
      v = $random(seed);
      wb(1, 8'h04, c[1] ? 32'h31 : 32'h00);
      wb(1, 8'h00, {24'h0, 1'b1, c[1:0], 5'h0});
      acc(0, 1, {8'h00, v[15:4], 4'h0}, 4'h8, c[0] ? 8 : 4);
      acc(0, 0, {8'h00, v[15:4], 4'h0}, 4'h8, 1);
    end
    wb(1, 8'h00, 32'h90);
    acc(0, 0, 24'h000100, 4'h0, 1);
    acc(1, 0, 24'h000102, 4'h0, 0);
    acc(0, 0, 24'hffff10, 4'h0, 1);
    $display("bursts and idle done");
    @(posedge clk_i);
    cpu_lock_i <= 1;
    dtc_breq_i <= 1;
    repeat (4) @(posedge clk_i);
    chk(cpu_back_o, 1);
    cpu_lock_i <= 0;
    for (k = 0; k < 20 && dtc_back_o !== 1'b1; k++) @(posedge clk_i);
    chk(dtc_back_o, 1);
    cpu_breq_i <= 0;
    acc(1, 0, 24'h001000, 4'h0, 0);
    dtc_breq_i <= 0;
    repeat (8) @(posedge clk_i);
    chk(cpu_back_o, 1);
    {cpu_breq_i, cpu_sleep_i, dtc_breq_i} <= 3'b111;
    repeat (3) @(posedge clk_i);
    chk(dtc_back_o, 1);
    $display("arbitration done");
    test_done(0);
  end
endmodule : burst_rom_idle_arbiter_bench
